// *** verilog/uart_xfn_regs.vh ***
`ifndef UART_XFN_REGS_VH
`define UART_XFN_REGS_VH
// Overview of operation
// - Setting nine_bit_mode makes both transmitter and receiver carry nine data bits.
// - The outgoing ninth bit sits in tx_ninth_bit and each received one lands in rx_ninth_bit.
// - The ninth bit is copied into the shifter in the same load as the eight data bits.
// - tx_ninth_bit keeps its value across characters until software rewrites it.
// - In stop the clocks halt and every register keeps its content.
// - The receive edge detector works in stop and wakes the processor when enabled.
// - After stop the block carries on from its kept state without reinitialising.
// - With loop_enable set, rx_source_select picks loopback at 0 and single wire at 1.
// - In loopback the transmitter output feeds the receiver internally.
// - In single wire the receiver listens to the transmit pin, or to the transmitter directly with wire_direction set, and the receive pin is unused.
// - In single wire with wire_direction clear the transmitter releases the transmit pin.
// - In single wire with wire_direction set the transmitter drives the transmit pin.
// - Any receive edge with the receiver enabled sets rx_edge_flag, cleared by writing one.
// - tx_complete_flag shows all data has gone and the line rests idle high.
`define REG_DATA        4'h0
`define REG_CONTROL_ONE 4'h1
`define REG_CONTROL_THR 4'h2
`define REG_STATUS_ONE  4'h3
`define REG_STATUS_TWO  4'h4
`define REG_IRQ_MASK    4'h5
`define REG_BAUD        4'h6
`define C1_NINE         0
`define C1_LOOP         1
`define C1_RX_SOURCE_SELECT         2
`define C1_TXEN         3
`define C1_RXEN         4
`define C3_TX9          0
`define C3_RX9          1
`define C3_DIR          2
`define ST_TX_BUFFER_EMPTY_FLAG         0
`define ST_TC           1
`define ST_RDRF         2
`define ST_RAF          3
`define ST_EDGE         4
`define BAUD_RESET      16'h0010
`endif

// *** verilog/uart_xfn.v ***
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
`include "uart_xfn_regs.vh"
module uart_xfn #(
  parameter DIV_W = 16
) (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        rxd_in,
  input  wire        txd_in,
  output wire        txd_out,
  output wire        txd_oe,
  output wire        rxd_in_use,
  output wire        irq,
  output wire        wake_req
);
  localparam S_IDLE = 2'h0;
  localparam S_SHIFT = 2'h1;
  localparam [3:0] BITS_NINE  = 4'hB;
  localparam [3:0] BITS_EIGHT = 4'hA;
  // Frames carry one start and one stop bit and no parity. Overrun keeps the unread
  // character, so software must empty the data register within one frame time.

  reg [4:0]       ctl1_q;
  reg [2:0]       ctl3_q;
  reg [DIV_W-1:0] baud_q;
  reg [4:0]       mask_q;
  reg             edge_ie_q;
  reg [7:0]       tbuf_q;
  reg             tbuf9_q;
  reg             tx_buffer_empty_flag_q;
  reg             edge_q;
  reg [7:0]       rbuf_q;
  reg             rdrf_q;
  reg             ack_q;
  reg             rx_prev_q;

  wire nine_bit_mode    = ctl1_q[`C1_NINE];
  wire loop_enable      = ctl1_q[`C1_LOOP];
  wire rx_source_select = ctl1_q[`C1_RX_SOURCE_SELECT];
  wire tx_enable        = ctl1_q[`C1_TXEN];
  wire rx_enable        = ctl1_q[`C1_RXEN];
  wire wire_direction   = ctl3_q[`C3_DIR];
  wire tx_ninth_bit     = ctl3_q[`C3_TX9];
  wire single_wire      = loop_enable & rx_source_select;
  wire loopback         = loop_enable & ~rx_source_select;

  // Transmitter: a shifter loaded from the buffer, one bit per baud period.
  reg [1:0]       tst_q;
  reg [9:0]       tsh_q;
  reg [3:0]       tcnt_q;
  reg [DIV_W-1:0] tdiv_q;
  reg             tline_q;
  wire            tick_t = (tdiv_q == {DIV_W{1'b0}});
  wire [3:0]      nbits = nine_bit_mode ? BITS_NINE : BITS_EIGHT;
  wire            tx_load = (tst_q == S_IDLE) & ~tx_buffer_empty_flag_q & tx_enable;

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tst_q   <= S_IDLE;
      tsh_q   <= 10'h3FF;
      tcnt_q  <= 4'h0;
      tdiv_q  <= {DIV_W{1'b0}};
      tline_q <= 1'b1;
    end
    else if (tst_q == S_IDLE)
    begin
      tline_q <= 1'b1;
      if (!tx_buffer_empty_flag_q && tx_enable)
      begin
        // Ninth bit moves with the data in one load.
        tsh_q   <= {1'b1, tbuf9_q, tbuf_q};
        tline_q <= 1'b0;
        tcnt_q  <= nbits - 4'h1;
        tdiv_q  <= baud_q;
        tst_q   <= S_SHIFT;
      end
    end
    else
    begin
      tdiv_q <= tick_t ? baud_q : tdiv_q - {{(DIV_W-1){1'b0}}, 1'b1};
      if (tick_t)
      begin
        if (tcnt_q == 4'h0)
        begin
          tst_q   <= S_IDLE;
          tline_q <= 1'b1;
        end
        else
        begin
          tline_q <= tsh_q[0];
          tcnt_q  <= tcnt_q - 4'h1;
          // In eight-bit mode skip the ninth position straight to stop.
          tsh_q   <= (!nine_bit_mode && tcnt_q == 4'h2) ?
                     {1'b1, 9'h1FF} : {1'b1, tsh_q[9:1]};
        end
      end
    end
  end

  wire tx_busy = (tst_q != S_IDLE);
  wire tx_complete_flag = tx_buffer_empty_flag_q & ~tx_busy & tline_q;
  assign txd_out = tline_q;
  // The pin is driven except in single wire with the direction set to listen.
  assign txd_oe = ~single_wire | wire_direction;
  assign rxd_in_use = ~single_wire;

  // Both pins cross in through three flops; a change counts once stages two and three agree.
  // Each pin keeps its own last agreed level so a disagreement never borrows the other line.
  wire [1:0] pin_raw = {txd_in, rxd_in};
  wire [1:0] pin_sync;
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_sync
      reg [2:0] sync_q;
      reg       level_q;
      always @(posedge core_clk or negedge rstn)
      begin
        if (!rstn)
        begin
          sync_q  <= 3'h7;
          level_q <= 1'b1;
        end
        else
        begin
          sync_q <= {sync_q[1:0], pin_raw[gi]};
          if (sync_q[2] == sync_q[1])
            level_q <= sync_q[2];
        end
      end
      assign pin_sync[gi] = (sync_q[2] == sync_q[1]) ? sync_q[2] : level_q;
    end
  endgenerate
  wire rx_pin  = pin_sync[0];
  wire wi_pin  = pin_sync[1];
  wire rx_line = loopback ? tline_q :
                 single_wire ? (wire_direction ? tline_q : wi_pin) :
                 rx_pin;
  wire rx_edge = (rx_line != rx_prev_q);

  // Receiver: start bit found, sample mid bit, frame of eight or nine bits.
  reg [1:0]       rst_q;
  reg [8:0]       rsh_q;
  reg [3:0]       rcnt_q;
  reg [DIV_W-1:0] rdiv_q;
  reg             r9_q;
  wire            tick_r = (rdiv_q == {DIV_W{1'b0}});
  wire            rx_active_flag = (rst_q != S_IDLE);
  wire            rx_done = tick_r && rx_active_flag && rcnt_q == 4'h0;
  wire            rx_ninth_bit = r9_q;

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rst_q     <= S_IDLE;
      rsh_q     <= 9'h000;
      rcnt_q    <= 4'h0;
      rdiv_q    <= {DIV_W{1'b0}};
      r9_q      <= 1'b0;
      rx_prev_q <= 1'b1;
    end
    else
    begin
      rx_prev_q <= rx_line;
      if (rst_q == S_IDLE)
      begin
        if (rx_enable && rx_prev_q && !rx_line)
        begin
          rdiv_q <= {1'b0, baud_q[DIV_W-1:1]};
          rcnt_q <= nbits - 4'h1;
          rst_q  <= S_SHIFT;
        end
      end
      else
      begin
        rdiv_q <= tick_r ? baud_q : rdiv_q - {{(DIV_W-1){1'b0}}, 1'b1};
        if (tick_r)
        begin
          rcnt_q <= rcnt_q - 4'h1;
          if (rcnt_q == 4'h0)
            rst_q <= S_IDLE;
          else if (rcnt_q == nbits - 4'h1)
          begin
            // A start bit that is high again at mid bit was noise, so hunt again.
            if (rx_line)
              rst_q <= S_IDLE;
          end
          else
            rsh_q <= nine_bit_mode ? {rx_line, rsh_q[8:1]} : {1'b0, rx_line, rsh_q[7:1]};
        end
      end
      if (rx_done && !rdrf_q && nine_bit_mode)
        r9_q <= rsh_q[8];
    end
  end

  // Avalon slave: reads take one wait cycle, writes none.
  assign avs_waitrequest = avs_read & ~ack_q;
  wire wr = avs_write;
  wire rd_data = avs_read & ack_q & (avs_address == `REG_DATA);
  wire [4:0] status;
  assign status[`ST_TX_BUFFER_EMPTY_FLAG] = tx_buffer_empty_flag_q;
  assign status[`ST_TC]   = tx_complete_flag;
  assign status[`ST_RDRF] = rdrf_q;
  assign status[`ST_RAF]  = rx_active_flag;
  assign status[`ST_EDGE] = edge_q;

  reg [31:0] rdata_d;
  always @*
  begin
    rdata_d = 32'h00000000;
    case (avs_address)
      `REG_DATA:        rdata_d = {23'h000000, rx_ninth_bit, rbuf_q};
      `REG_CONTROL_ONE: rdata_d = {27'h0000000, ctl1_q};
      `REG_CONTROL_THR: rdata_d = {29'h00000000, ctl3_q[2], rx_ninth_bit, ctl3_q[0]};
      `REG_STATUS_ONE:  rdata_d = {27'h0000000, status};
      `REG_STATUS_TWO:  rdata_d = {31'h00000000, edge_ie_q};
      `REG_IRQ_MASK:    rdata_d = {27'h0000000, mask_q};
      `REG_BAUD:        rdata_d = {{(32-DIV_W){1'b0}}, baud_q};
      default:          rdata_d = 32'h00000000;
    endcase
  end

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h00000000;
      ctl1_q       <= 5'h00;
      ctl3_q       <= 3'h0;
      baud_q       <= `BAUD_RESET;
      mask_q       <= 5'h00;
      edge_ie_q    <= 1'b0;
      tbuf_q       <= 8'h00;
      tbuf9_q      <= 1'b0;
      tx_buffer_empty_flag_q       <= 1'b1;
      edge_q       <= 1'b0;
      rbuf_q       <= 8'h00;
      rdrf_q       <= 1'b0;
    end
    else
    begin
      ack_q <= avs_read & ~ack_q;
      if (avs_read && !ack_q)
        avs_readdata <= rdata_d;
      if (wr && avs_address == `REG_CONTROL_ONE)
        ctl1_q <= avs_writedata[4:0];
      if (wr && avs_address == `REG_CONTROL_THR)
        ctl3_q <= {avs_writedata[`C3_DIR], 1'b0, avs_writedata[`C3_TX9]};
      if (wr && avs_address == `REG_STATUS_TWO)
        edge_ie_q <= avs_writedata[0];
      if (wr && avs_address == `REG_IRQ_MASK)
        mask_q <= avs_writedata[4:0];
      if (wr && avs_address == `REG_BAUD)
        baud_q <= avs_writedata[DIV_W-1:0];
      // Buffer load; tx_ninth_bit is sampled here, hence written first.
      if (wr && avs_address == `REG_DATA)
      begin
        tbuf_q  <= avs_writedata[7:0];
        tbuf9_q <= nine_bit_mode & tx_ninth_bit;
        tx_buffer_empty_flag_q  <= 1'b0;
      end
      else if (tx_load)
        tx_buffer_empty_flag_q <= 1'b1;
      if (rx_done && !rdrf_q)
      begin
        rbuf_q <= rsh_q[7:0];
        rdrf_q <= 1'b1;
      end
      else if (rd_data)
        rdrf_q <= 1'b0;
      // Set beats a same-cycle write-one clear.
      if (rx_enable && rx_edge)
        edge_q <= 1'b1;
      else if (wr && avs_address == `REG_STATUS_ONE && avs_writedata[`ST_EDGE])
        edge_q <= 1'b0;
    end
  end

  // Stop halts core_clk outside; nothing here reinitialises on resume.
  // The wake path also compares the raw selected line with the last synchronised level,
  // so an edge still raises wake_req while core_clk is halted in stop.
  wire raw_line = loopback ? tline_q :
                  single_wire ? (wire_direction ? tline_q : txd_in) :
                  rxd_in;
  wire raw_edge = (raw_line != rx_prev_q);
  assign wake_req = edge_ie_q & rx_enable & (rx_edge | raw_edge | edge_q);
  assign irq = |(status & mask_q) | wake_req;
endmodule

// *** dv/uart_xfn_monitor.sv ***
`timescale 1ns/1ps
module uart_xfn_monitor (
  input wire        core_clk,
  input wire        rstn,
  input wire [3:0]  avs_address,
  input wire        avs_read,
  input wire        avs_write,
  input wire [31:0] avs_readdata,
  input wire        avs_waitrequest,
  input wire        txd_out,
  input wire        irq,
  input wire        wake_req
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // The bench programs a four-cycle bit, so any level on the line must last that long.
  sequence line_low;
    !txd_out [*4];
  endsequence
  sequence line_high;
    txd_out [*4];
  endsequence
  a_read_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read answer not one cycle late");
  a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
    else $error("write was stalled");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address > 4'h6
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  a_rdata_held: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_low_bit_len: assert property ($fell(txd_out) |-> line_low)
    else $error("low bit shorter than a bit period");
  a_high_bit_len: assert property ($rose(txd_out) |-> line_high)
    else $error("high bit shorter than a bit period");
  a_wake_sticky: assert property (wake_req && !avs_write |=> wake_req)
    else $error("wake request dropped without a write");
  a_wake_to_irq: assert property (wake_req |-> irq)
    else $error("wake request without interrupt");
  a_irq_sticky: assert property (irq && !avs_write && !avs_read |=> irq)
    else $error("interrupt dropped without an access");
endmodule
bind uart_xfn uart_xfn_monitor u_mon (.core_clk, .rstn, .avs_address, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .txd_out, .irq, .wake_req);

// *** dv/uart_far_end.sv ***
`timescale 1ns/1ps
module uart_far_end #(
  parameter BIT_CYC = 4
) (
  input wire core_clk,
  output reg rx_line,
  output reg pin_line,
  output reg pin_oe
);
  initial begin
    rx_line = 1'b1;
    pin_line = 1'b1;
    pin_oe = 1'b0;
  end
  // Releases the shared pin after each frame; the pull-up then holds it idle.
  task send(input to_pin, input [7:0] v);
    integer i;
    reg [9:0] f;
    begin
      f = {1'b1, v, 1'b0};
      pin_oe <= to_pin;
      for (i = 0; i < 10; i = i + 1)
      begin
        if (to_pin) pin_line <= f[i];
        else rx_line <= f[i];
        repeat (BIT_CYC) @(posedge core_clk);
      end
      pin_oe <= 1'b0;
    end
  endtask
endmodule

// *** dv/uart_xfn_tb_top.sv ***
`timescale 1ns/1ps
`include "uart_xfn_regs.vh"
module uart_xfn_tb_top;
  reg         core_clk, rstn, stall, avs_read, avs_write;
  reg  [3:0]  avs_address;
  reg  [31:0] avs_writedata, q;
  wire [31:0] avs_readdata;
  wire        avs_waitrequest, txd_out, txd_oe, rxd_in_use, irq, wake_req;
  wire        far_rx, far_pin, far_oe;
  wire        txd_pin = txd_oe ? txd_out : (far_oe ? far_pin : 1'b1);
  integer     error_cnt, check_count, cycles;
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = stall ? core_clk : ~core_clk;
  end
  uart_xfn uut (.core_clk, .rstn, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .rxd_in(far_rx), .txd_in(txd_pin), .txd_out, .txd_oe,
    .rxd_in_use, .irq, .wake_req);
  uart_far_end far (.core_clk, .rx_line(far_rx), .pin_line(far_pin), .pin_oe(far_oe));
  task close_out;
    begin
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  always @(posedge core_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 20000)
    begin
      error_cnt = error_cnt + 1;
      close_out;
    end
  end
  task chk(input [8*12-1:0] n, input [31:0] e, input [31:0] g);
    begin
      check_count = check_count + 1;
      if (g !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  task acc(input w, input [3:0] a, input [31:0] d);
    reg ws;
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      ws = 1'b1;
      while (ws !== 1'b0)
      begin
        @(posedge core_clk);
        ws = avs_waitrequest;
        q = avs_readdata;
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge core_clk);
    end
  endtask
  task rdc(input [8*12-1:0] n, input [3:0] a, input [31:0] e);
    begin
      acc(1'b0, a, 32'h0);
      chk(n, e, q);
    end
  endtask
  task rx_wait;
    begin
      q = 32'h0;
      while (!q[`ST_RDRF]) acc(1'b0, `REG_STATUS_ONE, 32'h0);
    end
  endtask
  task tx(input [7:0] v);
    begin
      acc(1'b1, `REG_DATA, {24'h0, v});
      rx_wait;
    end
  endtask
  initial
  begin
    rstn = 1'b0; stall = 1'b0; avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0;
    avs_writedata = 32'h0; error_cnt = 0; check_count = 0; cycles = 0;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rdc("ctl1", `REG_CONTROL_ONE, 32'h0);
    rdc("status", `REG_STATUS_ONE, 32'h3);
    rdc("baud", `REG_BAUD, {16'h0, `BAUD_RESET});
    rdc("unmapped", 4'hF, 32'h0);
    acc(1'b1, `REG_BAUD, 32'h3);
    acc(1'b1, `REG_CONTROL_ONE, 32'h1B);
    acc(1'b1, `REG_CONTROL_THR, 32'h1);
    tx(8'hA5);
    rdc("ctl3 rx9", `REG_CONTROL_THR, 32'h3);
    rdc("data9", `REG_DATA, 32'h1A5);
    tx(8'h3C);
    rdc("data9 kept", `REG_DATA, 32'h13C);
    acc(1'b1, `REG_CONTROL_ONE, 32'h1A);
    acc(1'b1, `REG_CONTROL_THR, 32'h0);
    tx(8'h81);
    acc(1'b0, `REG_DATA, 32'h0);
    chk("data8", 32'h81, {24'h0, q[7:0]});
    rdc("rx9 frozen", `REG_CONTROL_THR, 32'h2);
    acc(1'b1, `REG_CONTROL_ONE, 32'h1B);
    tx(8'h5A);
    rdc("data9 zero", `REG_DATA, 32'h05A);
    acc(1'b1, `REG_CONTROL_THR, 32'h4);
    acc(1'b1, `REG_CONTROL_ONE, 32'h1E);
    @(negedge core_clk);
    chk("oe out", 32'h1, {31'h0, txd_oe});
    chk("rx pin free", 32'h0, {31'h0, rxd_in_use});
    @(posedge core_clk);
    tx(8'h66);
    acc(1'b0, `REG_DATA, 32'h0);
    chk("wire loop", 32'h66, {24'h0, q[7:0]});
    acc(1'b1, `REG_CONTROL_THR, 32'h0);
    @(negedge core_clk);
    chk("oe in", 32'h0, {31'h0, txd_oe});
    @(posedge core_clk);
    far.send(1'b1, 8'hC3);
    rx_wait;
    acc(1'b0, `REG_DATA, 32'h0);
    chk("wire in", 32'hC3, {24'h0, q[7:0]});
    acc(1'b1, `REG_CONTROL_ONE, 32'h18);
    acc(1'b1, `REG_STATUS_ONE, 32'h10);
    far.send(1'b0, 8'h3A);
    rx_wait;
    chk("edge flag", 32'h1, {31'h0, q[`ST_EDGE]});
    acc(1'b0, `REG_DATA, 32'h0);
    chk("pin rx", 32'h3A, {24'h0, q[7:0]});
    acc(1'b1, `REG_IRQ_MASK, 32'h10);
    @(negedge core_clk);
    chk("irq set", 32'h1, {31'h0, irq});
    @(posedge core_clk);
    acc(1'b1, `REG_STATUS_ONE, 32'h10);
    @(negedge core_clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    @(posedge core_clk);
    acc(1'b1, `REG_STATUS_TWO, 32'h1);
    far.send(1'b0, 8'h55);
    @(negedge core_clk);
    chk("wake", 32'h1, {31'h0, wake_req});
    @(posedge core_clk);
    rx_wait;
    acc(1'b0, `REG_DATA, 32'h0);
    rdc("pre stop", `REG_STATUS_ONE, 32'h13);
    stall <= 1'b1;
    #300 stall <= 1'b0;
    @(posedge core_clk);
    rdc("ctl1 kept", `REG_CONTROL_ONE, 32'h18);
    rdc("ctl2 kept", `REG_STATUS_TWO, 32'h1);
    close_out;
  end
endmodule
